/* hdl/sts_pkg.sv */
// Package for the scan trigger sequencer: commands, sources, sizes, states
package sts_pkg;

   // Scan list storage
   localparam int LIST_DEPTH = 16;
   localparam int IDX_W = 4;
   localparam int CHAN_W = 12;   // Module, section and channel packed into one relay code
   localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
   localparam logic [IDX_W:0] LEN_RESET = 5'h00;

   // Trigger line selection
   localparam int TTL_W = 8;
   localparam int TTL_SEL_W = 3;
   localparam logic [TTL_SEL_W-1:0] TTL_SEL_RESET = 3'h0;

   // Programmed trigger delay in cycles
   localparam int DLY_W = 16;
   localparam logic [DLY_W-1:0] DLY_RESET = 16'h0000;

   // Commands from the word-serial command decoder
   typedef enum logic [2:0] {
      STS_CMD_NONE     = 3'b000,
      STS_CMD_ABORT    = 3'b001,
      STS_CMD_ARM_ONCE = 3'b010,
      STS_CMD_ARM_CONT = 3'b011,
      STS_CMD_BUS_TRG  = 3'b100,
      STS_CMD_COMMON   = 3'b101,
      STS_CMD_IMM_TRG  = 3'b110
   } sts_cmd_t;

   // Trigger source selection
   typedef enum logic [1:0] {
      STS_SRC_BUS  = 2'b00,
      STS_SRC_HOLD = 2'b01,
      STS_SRC_IMM  = 2'b10,
      STS_SRC_TTL  = 2'b11
   } sts_src_t;

   // Trigger state machine
   typedef enum logic [1:0] {
      STS_ST_IDLE  = 2'b00,
      STS_ST_ARMED = 2'b01,
      STS_ST_DELAY = 2'b10
   } sts_state_t;

   // Relay drive command towards the relay driver
   typedef struct packed {
      logic open_en;
      logic [CHAN_W-1:0] open_chan;
      logic close_en;
      logic [CHAN_W-1:0] close_chan;
   } sts_relay_t;

   // Configuration from the command decoder
   typedef struct packed {
      sts_src_t src;
      logic [TTL_SEL_W-1:0] ttl_sel;
      logic [DLY_W-1:0] delay;
   } sts_cfg_t;

endpackage

/* hdl/sts_trig_filter.sv */
// Trigger qualification: source selection and hold blocking
`timescale 1ns/1ps
module sts_trig_filter (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire sts_pkg::sts_src_t src_i,
   input wire logic [sts_pkg::TTL_SEL_W-1:0] ttl_sel_i,
   input wire logic [sts_pkg::TTL_W-1:0] ttl_i,
   input wire sts_pkg::sts_cmd_t cmd_i,
   input wire logic cmd_valid_i,
   output logic trig_o,
   output logic trig_now_o
);

   logic ttl_prev;
   logic ttl_bit;
   logic ttl_rise;
   logic bus_cmd;
   logic imm_cmd;
   logic src_imm;

   // Selected line, rising edge only so a held level triggers once
   assign ttl_bit = ttl_i[ttl_sel_i];
   assign ttl_rise = ttl_bit & ~ttl_prev;
   // Common trigger acts exactly like the backplane trigger command
   assign bus_cmd = cmd_valid_i && (cmd_i == sts_pkg::STS_CMD_BUS_TRG || cmd_i == sts_pkg::STS_CMD_COMMON);
   assign imm_cmd = cmd_valid_i && cmd_i == sts_pkg::STS_CMD_IMM_TRG;
   assign src_imm = src_i == sts_pkg::STS_SRC_IMM;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ttl_prev <= 1'b0;
      end else begin
         ttl_prev <= ttl_bit;
      end
   end

   // Hold blocks every delayed source; the immediate command always gets through undelayed
   always_comb begin
      trig_o = 1'b0;
      case (src_i)
         sts_pkg::STS_SRC_BUS: trig_o = bus_cmd;
         sts_pkg::STS_SRC_TTL: trig_o = ttl_rise;
         sts_pkg::STS_SRC_IMM: trig_o = 1'b0;
         sts_pkg::STS_SRC_HOLD: trig_o = 1'b0;
         default: trig_o = 1'b0;
      endcase
      // Immediate source fires at once whenever armed
      trig_now_o = imm_cmd | src_imm;
   end

endmodule

/* hdl/sts_sequencer.sv */
// Scan trigger sequencer top: scan list, idle/armed/delay state machine, relay stepping
`timescale 1ns/1ps
// Summary of operation
// - Halt command always returns the trigger state machine to idle.
// - Halt command opens the scan-list relay that is currently closed.
// - In idle every trigger is discarded and no relay moves.
// - Single-shot and continuous arm commands both move idle to armed.
// - Trigger source is bus, hold, immediate or one selected TTL line.
// - Hold source ignores TTL, bus, common and immediate-source triggers.
// - Immediate-trigger command fires even under hold.
// - Immediate-trigger command skips the programmed trigger delay.
// - First trigger after arming closes the first list relay, opens nothing.
// - Each later trigger opens the previous relay then closes the next.
// - List entries from many modules and sections run in listed order.
// - Bus trigger command advances the scan only with bus source selected.
// - Common trigger command acts exactly like a bus trigger command.
module sts_sequencer (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire sts_pkg::sts_cmd_t cmd_i,
   input wire logic cmd_valid_i,
   input wire sts_pkg::sts_cfg_t cfg_i,
   input wire logic [sts_pkg::TTL_W-1:0] ttl_i,
   input wire logic list_clear_i,
   input wire logic list_wr_i,
   input wire logic [sts_pkg::CHAN_W-1:0] list_chan_i,
   output sts_pkg::sts_relay_t relay_o,
   output logic relay_valid_o,
   output logic armed_o,
   output logic chan_closed_o,
   output logic [sts_pkg::IDX_W:0] list_len_o
);

   sts_pkg::sts_state_t state;
   sts_pkg::sts_state_t next_state;
   logic [sts_pkg::CHAN_W-1:0] list_mem [sts_pkg::LIST_DEPTH];
   logic [sts_pkg::IDX_W:0] list_len;
   logic [sts_pkg::IDX_W-1:0] pos;
   logic closed;
   logic [sts_pkg::CHAN_W-1:0] closed_chan;
   logic [sts_pkg::DLY_W-1:0] dly_cnt;
   logic trig;
   logic trig_now;
   logic is_abort;
   logic is_arm;
   logic step;
   logic delayed_done;
   logic list_empty;
   logic [sts_pkg::IDX_W-1:0] next_pos;
   logic [sts_pkg::CHAN_W-1:0] step_chan;
   logic at_end;

   sts_trig_filter u_filter (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .src_i(cfg_i.src),
      .ttl_sel_i(cfg_i.ttl_sel),
      .ttl_i(ttl_i),
      .cmd_i(cmd_i),
      .cmd_valid_i(cmd_valid_i),
      .trig_o(trig),
      .trig_now_o(trig_now)
   );

   // Command decode
   assign is_abort = cmd_valid_i && cmd_i == sts_pkg::STS_CMD_ABORT;
   assign is_arm = cmd_valid_i && (cmd_i == sts_pkg::STS_CMD_ARM_ONCE || cmd_i == sts_pkg::STS_CMD_ARM_CONT);
   assign list_empty = list_len == 5'h00;
   assign delayed_done = state == sts_pkg::STS_ST_DELAY && dly_cnt == 16'h0000;
   // A step happens from armed on an immediate trigger or a zero delay, or when the delay runs out
   assign step = !is_abort && !list_empty &&
                 ((state == sts_pkg::STS_ST_ARMED && (trig_now || (trig && cfg_i.delay == 16'h0000))) ||
                  (state == sts_pkg::STS_ST_DELAY && (trig_now || delayed_done)));
   // Next list slot in listed order, wrapping at the end
   assign at_end = {1'b0, pos} + 5'h01 >= list_len;
   assign next_pos = closed ? (at_end ? sts_pkg::IDX_RESET : pos + 4'h1) : sts_pkg::IDX_RESET;
   assign step_chan = list_mem[next_pos];

   // State transitions
   always_comb begin
      next_state = state;
      case (state)
         sts_pkg::STS_ST_IDLE: begin
            if (is_arm) begin
               next_state = sts_pkg::STS_ST_ARMED;
            end
         end
         sts_pkg::STS_ST_ARMED: begin
            if (is_abort) begin
               next_state = sts_pkg::STS_ST_IDLE;
            end else if (trig && !trig_now && cfg_i.delay != 16'h0000) begin
               next_state = sts_pkg::STS_ST_DELAY;
            end
         end
         sts_pkg::STS_ST_DELAY: begin
            if (is_abort) begin
               next_state = sts_pkg::STS_ST_IDLE;
            end else if (step || delayed_done) begin
               next_state = sts_pkg::STS_ST_ARMED;
            end
         end
         default: next_state = sts_pkg::STS_ST_IDLE;
      endcase
   end

   // Scan list storage; writes while a scan runs are accepted, so load the list before arming
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || list_clear_i) begin
         list_len <= sts_pkg::LEN_RESET;
      end else if (list_wr_i && list_len < 5'(sts_pkg::LIST_DEPTH)) begin
         list_mem[list_len[sts_pkg::IDX_W-1:0]] <= list_chan_i;
         list_len <= list_len + 5'h01;
      end
   end

   // State register and delay counter
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= sts_pkg::STS_ST_IDLE;
         dly_cnt <= sts_pkg::DLY_RESET;
      end else begin
         state <= next_state;
         if (state == sts_pkg::STS_ST_ARMED) begin
            dly_cnt <= cfg_i.delay - 16'h0001;
         end else if (dly_cnt != 16'h0000) begin
            dly_cnt <= dly_cnt - 16'h0001;
         end
      end
   end

   // Relay stepping; every output comes from a flip-flop
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pos <= sts_pkg::IDX_RESET;
         closed <= 1'b0;
         closed_chan <= '0;
         relay_o <= '0;
         relay_valid_o <= 1'b0;
      end else begin
         relay_valid_o <= 1'b0;
         if (is_abort && state != sts_pkg::STS_ST_IDLE && closed) begin
            relay_o <= '{open_en: 1'b1, open_chan: closed_chan, close_en: 1'b0, close_chan: '0};
            relay_valid_o <= 1'b1;
            closed <= 1'b0;
            pos <= sts_pkg::IDX_RESET;
         end else if (is_abort && state != sts_pkg::STS_ST_IDLE) begin
            pos <= sts_pkg::IDX_RESET;
         end else if (step) begin
            relay_o <= '{open_en: closed, open_chan: closed_chan, close_en: 1'b1, close_chan: step_chan};
            relay_valid_o <= 1'b1;
            closed <= 1'b1;
            closed_chan <= step_chan;
            pos <= next_pos;
         end
      end
   end

   // Status copies
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         armed_o <= 1'b0;
         chan_closed_o <= 1'b0;
         list_len_o <= sts_pkg::LEN_RESET;
      end else begin
         armed_o <= next_state != sts_pkg::STS_ST_IDLE;
         chan_closed_o <= closed;
         list_len_o <= list_len;
      end
   end

   // Abort always lands in idle one cycle later
   property p_abort_idle;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      is_abort |=> state == sts_pkg::STS_ST_IDLE;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("abort did not idle");

   // Abort with a relay closed opens exactly that relay
   property p_abort_open;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (is_abort && state != sts_pkg::STS_ST_IDLE && closed) |=>
         relay_valid_o && relay_o.open_en && !relay_o.close_en && relay_o.open_chan == $past(closed_chan);
   endproperty
   a_abort_open: assert property (p_abort_open) else $error("abort did not open relay");

   // Nothing moves while idle
   property p_idle_quiet;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state == sts_pkg::STS_ST_IDLE |=> !relay_valid_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("relay moved in idle");

   // Arm from idle reaches armed
   property p_arm;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (state == sts_pkg::STS_ST_IDLE && is_arm) |=> state == sts_pkg::STS_ST_ARMED && armed_o;
   endproperty
   a_arm: assert property (p_arm) else $error("arm failed");

   // Hold source with no immediate command never steps from armed; a halt may still open the relay
   property p_hold;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (state == sts_pkg::STS_ST_ARMED && cfg_i.src == sts_pkg::STS_SRC_HOLD && !trig_now && !is_abort) |=>
         !relay_valid_o;
   endproperty
   a_hold: assert property (p_hold) else $error("hold did not block");

   // Immediate command steps next cycle regardless of source and delay
   property p_imm;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (state != sts_pkg::STS_ST_IDLE && !list_empty && cmd_valid_i && cmd_i == sts_pkg::STS_CMD_IMM_TRG) |=>
         relay_valid_o && relay_o.close_en;
   endproperty
   a_imm: assert property (p_imm) else $error("immediate trigger ignored");

   // First step after arming opens nothing
   sequence s_first_step;
      step && !closed;
   endsequence
   property p_first;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_first_step |=> relay_o.close_en && !relay_o.open_en && relay_o.close_chan == $past(list_mem[0]);
   endproperty
   a_first: assert property (p_first) else $error("first step wrong");

   // Later steps open the previously closed relay
   property p_next;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (step && closed) |=> relay_o.open_en && relay_o.open_chan == $past(closed_chan);
   endproperty
   a_next: assert property (p_next) else $error("previous relay not opened");

   // Halt while idle changes nothing
   property p_idle_abort;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (is_abort && state == sts_pkg::STS_ST_IDLE) |=> !relay_valid_o && state == sts_pkg::STS_ST_IDLE;
   endproperty
   a_idle_abort: assert property (p_idle_abort) else $error("idle abort acted");

endmodule

/* testbench/sts_cmdr_model.sv */
// Command source model: one-cycle command pulses as the system commander issues them
`timescale 1ns/1ps
module sts_cmdr_model (
   input wire logic core_clk_i,
   output sts_pkg::sts_cmd_t cmd_o,
   output logic cmd_valid_o
);
   // Idle bus at time zero
   initial begin
      cmd_o = sts_pkg::STS_CMD_NONE;
      cmd_valid_o = 1'b0;
   end
   // Code parks on NONE after the pulse so a stale code never looks qualified
   task automatic send(input sts_pkg::sts_cmd_t c);
      cmd_o = c;
      cmd_valid_o = 1'b1;
      @(posedge core_clk_i);
      #2;
      cmd_valid_o = 1'b0;
      cmd_o = sts_pkg::STS_CMD_NONE;
   endtask
endmodule

/* testbench/sts_sequencer_tb.sv */
// Bench for the scan trigger sequencer: pseudo-random scan list and TTL line, fixed sources and command sequence
`timescale 1ns/1ps
module sts_sequencer_tb;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   sts_pkg::sts_cmd_t cmd;
   logic cmd_valid;
   sts_pkg::sts_cfg_t cfg = '0;
   logic [7:0] ttl = 8'h00;
   logic list_clear = 1'b0;
   logic list_wr = 1'b0;
   logic [11:0] list_chan = 12'h000;
   sts_pkg::sts_relay_t relay;
   logic relay_valid;
   logic armed;
   logic chan_closed;
   logic [4:0] list_len;
   int bad_count = 0;
   int checks = 0;
   int k;
   int n = 0;
   int pos = 0;
   logic closed = 1'b0;
   logic [11:0] cur = 12'h000;
   logic [11:0] lst [16];
   logic [15:0] lfsr = 16'h9d1c;

   sts_cmdr_model i_sts_cmdr_model (.core_clk_i(core_clk_i), .cmd_o(cmd), .cmd_valid_o(cmd_valid));
   sts_sequencer i_sts_sequencer (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd),
      .cmd_valid_i(cmd_valid), .cfg_i(cfg), .ttl_i(ttl), .list_clear_i(list_clear), .list_wr_i(list_wr),
      .list_chan_i(list_chan), .relay_o(relay), .relay_valid_o(relay_valid), .armed_o(armed),
      .chan_closed_o(chan_closed), .list_len_o(list_len));

   // Clock, 25 ns period
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   function automatic logic [15:0] lfsr_next(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Scan position wraps to the first entry after the last
   function automatic int next_pos(int p, int len);
      return (p + 1) % len;
   endfunction

   task tick();
      @(posedge core_clk_i);
      #2;
   endtask
   task chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (e !== g) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wait_valid(int lim);
      int w;
      w = 0;
      while (relay_valid !== 1'b1 && w < lim) begin
         tick();
         w++;
      end
      chk("relay_valid", 1, relay_valid);
   endtask
   // Expected step: open the held relay if any, close the next list entry
   task step_chk(int lim);
      wait_valid(lim);
      chk("open_en", closed, relay.open_en);
      if (closed) chk("open_chan", cur, relay.open_chan);
      chk("close_en", 1, relay.close_en);
      chk("close_chan", lst[pos], relay.close_chan);
      closed = 1'b1;
      cur = lst[pos];
      pos = next_pos(pos, n);
      tick();
   endtask
   task no_step(int c);
      int seen;
      seen = 0;
      for (int i = 0; i < c; i++) begin
         if (relay_valid !== 1'b0) seen = 1;
         tick();
      end
      chk("no_step", 0, seen);
   endtask
   task abort_chk();
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_ABORT);
      wait_valid(20);
      chk("abort_open_en", 1, relay.open_en);
      chk("abort_open_chan", cur, relay.open_chan);
      chk("abort_close_en", 0, relay.close_en);
      closed = 1'b0;
      pos = 0;
      tick();
      chk("abort_armed", 0, armed);
      chk("abort_chan_closed", 0, chan_closed);
   endtask
   task end_sim();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog, far beyond the hundred or so cycles the sequence needs
   initial begin
      repeat (3000) @(posedge core_clk_i);
      bad_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk_i);
      #2;
      sys_rst_i = 1'b0;
      chk("armed_rst", 0, armed);
      chk("len_rst", 0, list_len);
      for (k = 0; k < 5; k++) begin
         lfsr = lfsr_next(lfsr);
         lst[k] = lfsr[11:0];
         list_chan = lfsr[11:0];
         list_wr = 1'b1;
         tick();
      end
      list_wr = 1'b0;
      n = 5;
      tick();
      chk("list_len", 5, list_len);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      no_step(4);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_ABORT);
      no_step(4);
      chk("armed_idle", 0, armed);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_ARM_ONCE);
      tick();
      chk("armed_once", 1, armed);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      step_chk(20);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      step_chk(20);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_COMMON);
      step_chk(20);
      chk("chan_closed", 1, chan_closed);
      // Hold blocks every source but the immediate command
      cfg.src = sts_pkg::STS_SRC_HOLD;
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      no_step(3);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_COMMON);
      no_step(3);
      ttl[cfg.ttl_sel] = 1'b1;
      no_step(3);
      ttl = 8'h00;
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_IMM_TRG);
      step_chk(20);
      // Random TTL line; an unselected line and the bus command must not step
      cfg.src = sts_pkg::STS_SRC_TTL;
      cfg.ttl_sel = lfsr[2:0];
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      no_step(3);
      ttl[cfg.ttl_sel ^ 3'h1] = 1'b1;
      no_step(3);
      ttl[cfg.ttl_sel] = 1'b1;
      step_chk(20);
      ttl = 8'h00;
      // Delay of five cycles holds a bus step back; this step also wraps the list
      cfg.src = sts_pkg::STS_SRC_BUS;
      cfg.delay = 16'h0005;
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      no_step(3);
      step_chk(20);
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_IMM_TRG);
      step_chk(2);
      // Immediate command while a delayed bus step is pending steps at once
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      tick();
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_IMM_TRG);
      step_chk(2);
      abort_chk();
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_ARM_CONT);
      tick();
      chk("armed_cont", 1, armed);
      cfg.delay = 16'h0000;
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_BUS_TRG);
      step_chk(20);
      abort_chk();
      // Immediate source steps on every armed cycle until the source is changed back
      i_sts_cmdr_model.send(sts_pkg::STS_CMD_ARM_ONCE);
      tick();
      cfg.src = sts_pkg::STS_SRC_IMM;
      step_chk(5);
      cfg.src = sts_pkg::STS_SRC_BUS;
      step_chk(1);
      abort_chk();
      list_clear = 1'b1;
      tick();
      list_clear = 1'b0;
      tick();
      chk("list_cleared", 0, list_len);
      end_sim();
   end
endmodule
